// file: cocr_host.sv
// cocr_host: behavioural two-wire host controller, 800 ns serial clock.
// assumes: data line pulled up; the bench resolves it from sda_low and the device.
`timescale 1ns/1ps
`default_nettype none
module cocr_host (
    input wire logic mclk,
    input wire logic sda,
    output logic scl,
    output logic sda_low
);
    logic ack_all;
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
        ack_all = 1'b1;
    end
    // every change lands a fixed delay after an edge, never on it
    task automatic edges(input int n);
        repeat (n) @(posedge mclk);
        #5;
    endtask : edges
    // start, also the repeated start from scl low
    task automatic start();
        edges(2);
        sda_low = 1'b0;
        edges(2);
        scl = 1'b1;
        edges(2);
        sda_low = 1'b1;
        edges(2);
        scl = 1'b0;
    endtask : start
    task automatic stop();
        edges(2);
        sda_low = 1'b1;
        edges(2);
        scl = 1'b1;
        edges(2);
        sda_low = 1'b0;
        edges(4);
    endtask : stop
    // one bit: data set mid-low, line read just before scl falls
    task automatic bit_io(input logic b, output logic r);
        edges(2);
        sda_low = !b;
        edges(2);
        scl = 1'b1;
        edges(4);
        r = sda;
        scl = 1'b0;
    endtask : bit_io
    task automatic put(input logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(b[i], r);
        bit_io(1'b1, r);
        ack_all = ack_all & !r;
    endtask : put
    // ack every byte, not-ack the last one
    task automatic get(input logic last, output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
        bit_io(last, r);
    endtask : get
endmodule : cocr_host
`default_nettype wire

// file: cocr_pkg.sv
// cocr_pkg: constants, register map, field layouts and types for the
// clock output control register group.
// assumes: registers are reached over the two-wire serial port only.
package cocr_pkg;
    // serial port address, write form is this shifted left with a zero
    localparam logic [6:0] SLV_ADDR = 7'h69;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] BIT_FIRST_TX = 4'h1;

    // register indices
    localparam logic [7:0] ADDR_OUT_EN = 8'h02;
    localparam logic [7:0] ADDR_OUT_CTL = 8'h03;
    localparam logic [7:0] ADDR_DIV_HI = 8'h04;
    localparam logic [7:0] ADDR_DIV_LO = 8'h05;
    localparam logic [7:0] ADDR_RSVD6 = 8'h06;

    // reset values and fixed read values
    localparam logic [7:0] OUT_EN_RST = 8'hFF;
    localparam logic [7:0] OUT_CTL_RST = 8'h30;
    localparam logic [7:0] OUT_CTL_WMASK = 8'h3F;
    localparam logic [7:0] DIV_HI_FIXED = 8'hCC;
    localparam int DIV_MSB_BIT = 0;
    localparam logic DIV_MSB_RST = 1'b0;
    localparam logic [7:0] DIV_LO_166 = 8'h7D;
    localparam logic [7:0] DIV_LO_OTHER = 8'h64;
    localparam logic [7:0] RSVD6_VAL = 8'hC1;
    localparam logic [7:0] UNMAPPED_VAL = 8'h00;
    localparam logic [7:0] BYTE_COUNT_RST = 8'h07;
    localparam logic [1:0] FS_CODE_166_RST = 2'h3;
    localparam logic [1:0] STRAP_SETTLE = 2'h2;

    // output enable register, msb first
    typedef struct packed {
        logic proc_clk0_out_en;
        logic proc_clk1_out_en;
        logic proc_clk2_out_en;
        logic serial_ref0_out_en;
        logic serial_ref1_out_en;
        logic serial_ref2_out_en;
        logic dot_clk_out_en;
        logic display_clk_out_en;
    } cocr_oe_t;

    // output control register, msb first
    typedef struct packed {
        logic [1:0] rsvd;
        logic ref_clk_out_en;
        logic [1:0] ref_slew;
        logic proc_clk0_stoppable;
        logic proc_clk1_stoppable;
        logic proc_clk2_stoppable;
    } cocr_ctl_t;

    // everything the analog side sees
    typedef struct packed {
        cocr_oe_t en;
        logic ref_clk_out_en;
        logic [1:0] ref_slew;
        logic [8:0] proc_pll_fb_div;
    } cocr_out_t;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0000,
        ST_ADDR = 4'b0001,
        ST_ADDR_ACK_WR = 4'b0010,
        ST_ADDR_ACK_RD = 4'b0011,
        ST_CMD = 4'b0100,
        ST_CMD_ACK = 4'b0101,
        ST_WDATA = 4'b0110,
        ST_WDATA_ACK = 4'b0111,
        ST_RDATA = 4'b1000,
        ST_RACK = 4'b1001
    } cocr_state_t;
endpackage : cocr_pkg

// file: cocr_regs.sv
// cocr_regs: clock output control registers behind a two-wire serial
// slave with indexed block write and block read.
// assumes: scl/sda sampled by mclk (scl far slower than mclk); sda is
// open drain, resolved outside from sda_oe.
`timescale 1ns/1ps
`default_nettype none
module cocr_regs #(
    parameter logic [7:0] BYTE_COUNT = cocr_pkg::BYTE_COUNT_RST,
    parameter logic [1:0] FS_CODE_166 = cocr_pkg::FS_CODE_166_RST
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic ce,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire logic processor_clock_halt_n,
    input wire logic [1:0] freq_sel,
    output cocr_pkg::cocr_out_t clk_ctrl
);
    import cocr_pkg::*;

    logic scl_s, sda_s, halt_n_s;
    logic [1:0] fs_s;
    logic scl_p_q, sda_p_q;
    cocr_state_t state_q;
    logic [7:0] sh_q;
    logic [3:0] bit_q;
    logic [7:0] idx_q;
    logic rd_first_q, wr_first_q;
    cocr_oe_t oe_q;
    cocr_ctl_t ctl_q;
    logic div_msb_q;
    logic [7:0] div_lo_q;
    logic strap_done_q;
    logic [1:0] strap_cnt_q;

    // pins cross into mclk; bus idles high, halt idles released
    cocr_sync #(
        .WIDTH(5),
        .RESET_VAL(5'h1C)
    ) u_sync (
        .mclk(mclk),
        .reset_n(reset_n),
        .ce(ce),
        .async_in({scl_i, sda_i, processor_clock_halt_n, freq_sel}),
        .sync_out({scl_s, sda_s, halt_n_s, fs_s})
    );

    // bus events from the synchronised lines
    wire scl_rise = scl_s & ~scl_p_q;
    wire scl_fall = ~scl_s & scl_p_q;
    wire start_c = scl_s & scl_p_q & sda_p_q & ~sda_s;
    wire stop_c = scl_s & scl_p_q & ~sda_p_q & sda_s;
    wire byte_done = (bit_q == BITS_PER_BYTE);
    wire addr_hit = (sh_q[7:1] == SLV_ADDR);

    // read-back selection; reserved parts read their fixed values
    wire [7:0] rd_byte =
        (idx_q == ADDR_OUT_EN) ? oe_q :
        (idx_q == ADDR_OUT_CTL) ? ctl_q :
        (idx_q == ADDR_DIV_HI) ? (DIV_HI_FIXED | {7'h00, div_msb_q}) :
        (idx_q == ADDR_DIV_LO) ? div_lo_q :
        (idx_q == ADDR_RSVD6) ? RSVD6_VAL :
        UNMAPPED_VAL;
    // first byte of a block read is the byte count
    wire [7:0] tx_byte = rd_first_q ? BYTE_COUNT : rd_byte;

    // write strobes: first data byte of a block write is its count
    wire wr_en = scl_fall & (state_q == ST_WDATA) & byte_done & ~wr_first_q;
    wire we_oe = wr_en & (idx_q == ADDR_OUT_EN);
    wire we_ctl = wr_en & (idx_q == ADDR_OUT_CTL);
    wire we_hi = wr_en & (idx_q == ADDR_DIV_HI);
    wire we_lo = wr_en & (idx_q == ADDR_DIV_LO);

    // halted pairs: only those marked stoppable drop out
    wire halt = ~halt_n_s;
    wire stop0 = ctl_q.proc_clk0_stoppable & halt;
    wire stop1 = ctl_q.proc_clk1_stoppable & halt;
    wire stop2 = ctl_q.proc_clk2_stoppable & halt;

    // previous line levels for edge detection
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else if (ce) begin
            scl_p_q <= scl_s;
            sda_p_q <= sda_s;
        end
    end

    // serial slave: bits taken on scl rise, sda changed on scl fall
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= ST_IDLE;
            sh_q <= 8'h00;
            bit_q <= 4'h0;
            idx_q <= 8'h00;
            rd_first_q <= 1'b0;
            wr_first_q <= 1'b0;
            sda_o <= 1'b1;
            sda_oe <= 1'b0;
        end else if (ce) begin
            if (start_c) begin
                // a repeated start keeps the index for the read phase
                state_q <= ST_ADDR;
                bit_q <= 4'h0;
                sda_o <= 1'b1;
                sda_oe <= 1'b0;
            end else if (stop_c) begin
                state_q <= ST_IDLE;
                sda_o <= 1'b1;
                sda_oe <= 1'b0;
            end else if (scl_rise) begin
                case (state_q)
                    ST_ADDR, ST_CMD, ST_WDATA: begin
                        sh_q <= {sh_q[6:0], sda_s};
                        bit_q <= bit_q + 4'h1;
                    end
                    ST_RACK: begin
                        if (sda_s) begin
                            state_q <= ST_IDLE;
                        end
                    end
                    default: begin
                    end
                endcase
            end else if (scl_fall) begin
                case (state_q)
                    ST_ADDR: begin
                        if (byte_done) begin
                            bit_q <= 4'h0;
                            if (addr_hit) begin
                                sda_o <= 1'b0;
                                sda_oe <= 1'b1;
                                rd_first_q <= sh_q[0];
                                state_q <= sh_q[0] ? ST_ADDR_ACK_RD : ST_ADDR_ACK_WR;
                            end else begin
                                state_q <= ST_IDLE;
                            end
                        end
                    end
                    ST_CMD: begin
                        if (byte_done) begin
                            idx_q <= sh_q;
                            bit_q <= 4'h0;
                            sda_o <= 1'b0;
                            sda_oe <= 1'b1;
                            state_q <= ST_CMD_ACK;
                        end
                    end
                    ST_WDATA: begin
                        if (byte_done) begin
                            bit_q <= 4'h0;
                            sda_o <= 1'b0;
                            sda_oe <= 1'b1;
                            wr_first_q <= 1'b0;
                            if (!wr_first_q) begin
                                idx_q <= idx_q + 8'h01;
                            end
                            state_q <= ST_WDATA_ACK;
                        end
                    end
                    ST_ADDR_ACK_WR: begin
                        sda_o <= 1'b1;
                        sda_oe <= 1'b0;
                        state_q <= ST_CMD;
                    end
                    ST_CMD_ACK: begin
                        sda_o <= 1'b1;
                        sda_oe <= 1'b0;
                        wr_first_q <= 1'b1;
                        state_q <= ST_WDATA;
                    end
                    ST_WDATA_ACK: begin
                        sda_o <= 1'b1;
                        sda_oe <= 1'b0;
                        state_q <= ST_WDATA;
                    end
                    ST_ADDR_ACK_RD, ST_RACK: begin
                        // ack bit over (ours on the address, else the host's): next byte's msb goes out now
                        sh_q <= {tx_byte[6:0], 1'b0};
                        sda_o <= tx_byte[7];
                        sda_oe <= ~tx_byte[7];
                        bit_q <= BIT_FIRST_TX;
                        rd_first_q <= 1'b0;
                        if (!rd_first_q) begin
                            idx_q <= idx_q + 8'h01;
                        end
                        state_q <= ST_RDATA;
                    end
                    ST_RDATA: begin
                        if (byte_done) begin
                            bit_q <= 4'h0;
                            sda_o <= 1'b1;
                            sda_oe <= 1'b0;
                            state_q <= ST_RACK;
                        end else begin
                            sh_q <= {sh_q[6:0], 1'b0};
                            sda_o <= sh_q[7];
                            sda_oe <= ~sh_q[7];
                            bit_q <= bit_q + 4'h1;
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // register bank; reserved control bits are masked off on write
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            oe_q <= OUT_EN_RST;
            ctl_q <= OUT_CTL_RST;
            div_msb_q <= DIV_MSB_RST;
        end else if (ce) begin
            if (we_oe) begin
                oe_q <= sh_q;
            end
            if (we_ctl) begin
                ctl_q <= sh_q & OUT_CTL_WMASK;
            end
            if (we_hi) begin
                div_msb_q <= sh_q[DIV_MSB_BIT];
            end
        end
    end

    // frequency straps settle through the synchroniser, then load once
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            strap_cnt_q <= 2'h0;
            strap_done_q <= 1'b0;
            div_lo_q <= DIV_LO_OTHER;
        end else if (ce) begin
            if (!strap_done_q) begin
                if (strap_cnt_q == STRAP_SETTLE) begin
                    div_lo_q <= (fs_s == FS_CODE_166) ? DIV_LO_166 : DIV_LO_OTHER;
                    strap_done_q <= 1'b1;
                end else begin
                    strap_cnt_q <= strap_cnt_q + 2'h1;
                end
            end else if (we_lo) begin
                div_lo_q <= sh_q;
            end
        end
    end

    // buffer controls registered so the analog side sees clean levels
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            clk_ctrl <= '0;
        end else if (ce) begin
            clk_ctrl.en <= oe_q;
            clk_ctrl.en.proc_clk0_out_en <= oe_q.proc_clk0_out_en & ~stop0;
            clk_ctrl.en.proc_clk1_out_en <= oe_q.proc_clk1_out_en & ~stop1;
            clk_ctrl.en.proc_clk2_out_en <= oe_q.proc_clk2_out_en & ~stop2;
            clk_ctrl.ref_clk_out_en <= ctl_q.ref_clk_out_en;
            clk_ctrl.ref_slew <= ctl_q.ref_slew;
            clk_ctrl.proc_pll_fb_div <= {div_msb_q, div_lo_q};
        end
    end
endmodule : cocr_regs
`default_nettype wire

// file: cocr_regs_asserts.sv
// cocr_regs_asserts: port-level checks of the clock output control registers.
// assumes: bound into cocr_regs; serial clock far slower than mclk, scl idles high.
`timescale 1ns/1ps
`default_nettype none
module cocr_regs_asserts #(
    parameter logic [7:0] BYTE_COUNT = cocr_pkg::BYTE_COUNT_RST,
    parameter logic [1:0] FS_CODE_166 = cocr_pkg::FS_CODE_166_RST
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic ce,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe,
    input wire logic processor_clock_halt_n,
    input wire logic [1:0] freq_sel,
    input wire cocr_pkg::cocr_out_t clk_ctrl
);
    import cocr_pkg::*;
    logic [3:0] age_q;
    logic [3:0] age_d;
    wire settled;
    // first load and strap latch land before settled, so they never look like writes;
    // age counts enabled edges only, so a frozen start cannot fake a late strap load
    assign settled = (age_q == 4'hF);
    assign age_d = settled ? age_q : age_q + 4'h1;
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) age_q <= 4'h0;
        else if (ce) age_q <= age_d;
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    // register-driven fields may only move a few cycles after scl went low
    a_reset_quiet: assert property (disable iff (1'b0)
        !reset_n |-> clk_ctrl == '0 && !sda_oe) else $error("outputs active in reset");
    a_first_load: assert property (
        $rose(reset_n) && ce |=> clk_ctrl.en == 8'hFF && clk_ctrl.ref_clk_out_en
        && clk_ctrl.ref_slew == 2'h2 && clk_ctrl.proc_pll_fb_div == 9'h064)
        else $error("first load after reset wrong");
    a_halt_drop: assert property (
        settled && $fell(clk_ctrl.en.proc_clk0_out_en)
        |-> !$past(processor_clock_halt_n, 3) || !$past(scl_i, 3))
        else $error("proc pair 0 dropped without halt or write");
    a_halt_resume: assert property (
        settled && $rose(clk_ctrl.en.proc_clk2_out_en)
        |-> $past(processor_clock_halt_n, 3) || !$past(scl_i, 3))
        else $error("proc pair 2 rose while halted");
    a_ref_write: assert property (
        settled && $changed(clk_ctrl.ref_clk_out_en) |-> !$past(scl_i, 3))
        else $error("ref enable moved outside a write");
    a_slew_write: assert property (
        settled && $changed(clk_ctrl.ref_slew) |-> !$past(scl_i, 3))
        else $error("edge rate moved outside a write");
    a_div_write: assert property (
        settled && $changed(clk_ctrl.proc_pll_fb_div) |-> !$past(scl_i, 3))
        else $error("divider moved outside a write");
    a_other_en_write: assert property (
        settled && $changed(clk_ctrl.en[4:0]) |-> !$past(scl_i, 3))
        else $error("serial, dot or display enable moved outside a write");
    a_answer_low: assert property (
        $changed(sda_oe) |-> !$past(scl_i, 3)) else $error("data line turned with scl high");
    // open drain: the device may only ever pull the line low
    a_drive_low_only: assert property (
        sda_oe |-> !sda_o) else $error("data line driven high");
    // strap latched on the third enabled edge, driven out on the fourth
    a_strap_load: assert property (
        age_q == 4'h4 |-> clk_ctrl.proc_pll_fb_div[7:0] ==
        ((freq_sel == FS_CODE_166) ? DIV_LO_166 : DIV_LO_OTHER))
        else $error("divider low byte not loaded from straps");
endmodule : cocr_regs_asserts
bind cocr_regs cocr_regs_asserts #(.BYTE_COUNT(BYTE_COUNT), .FS_CODE_166(FS_CODE_166)) chk (
    .mclk(mclk), .reset_n(reset_n), .ce(ce), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
    .sda_oe(sda_oe), .processor_clock_halt_n(processor_clock_halt_n),
    .freq_sel(freq_sel), .clk_ctrl(clk_ctrl));
`default_nettype wire

// file: cocr_sync.sv
// cocr_sync: two-flop synchroniser bank for pin inputs.
// assumes: inputs are asynchronous to mclk; first stage feeds only second.
`timescale 1ns/1ps
`default_nettype none
module cocr_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic ce,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;

    // two stages; clock enable freezes both
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            meta_q <= RESET_VAL;
            sync_out <= RESET_VAL;
        end else if (ce) begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule : cocr_sync
`default_nettype wire

// file: test_clock_output_control_regs.sv
// test_clock_output_control_regs: table of register writes, then reset, halt and refusals.
// assumes: cocr_host is the only serial master; checker arrives by bind.
`timescale 1ns/1ps
`default_nettype none
module test_clock_output_control_regs;
    import cocr_pkg::*;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic ce = 1'b1;
    logic halt_n = 1'b1;
    logic [1:0] freq_sel = 2'h1;
    logic scl;
    logic host_low;
    logic sda_o;
    logic sda_oe;
    wire sda_w;
    cocr_out_t clk_ctrl;
    int err_count = 0;
    int checks_done = 0;
    logic [15:0] got;
    logic [7:0] sh_oe = 8'hFF;
    logic [7:0] sh_ctl = 8'h30;
    logic [8:0] sh_div = 9'h064;
    // index, data written, value read back
    logic [23:0] rows [9] = '{24'h020000, 24'h02A5A5, 24'h03FF3F, 24'h031212, 24'h0400CC,
        24'h04FFCD, 24'h053C3C, 24'h0600C1, 24'h105500};
    always #50 mclk = ~mclk;
    // open-drain line with pull-up: low if either side pulls
    assign sda_w = !(host_low || (sda_oe && !sda_o));
    cocr_host host (.mclk(mclk), .sda(sda_w), .scl(scl), .sda_low(host_low));
    cocr_regs uut (.mclk(mclk), .reset_n(reset_n), .ce(ce), .scl_i(scl), .sda_i(sda_w),
        .sda_o(sda_o), .sda_oe(sda_oe), .processor_clock_halt_n(halt_n),
        .freq_sel(freq_sel), .clk_ctrl(clk_ctrl));
    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %0t: saw %h wanted %h", $time, seen, exp);
        end
    endtask : chk
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : stop_test
    // straps held well past the latch point
    task automatic do_reset(input logic [1:0] fs);
        host.edges(1);
        reset_n = 1'b0;
        freq_sel = fs;
        host.edges(4);
        reset_n = 1'b1;
        host.edges(10);
    endtask : do_reset
    task automatic wr(input logic [7:0] idx, input logic [15:0] d, input logic [7:0] n);
        host.ack_all = 1'b1;
        host.start();
        host.put(8'hD2);
        host.put(idx);
        host.put(n);
        for (int i = 0; i < n; i++) host.put(d[15 - 8 * i -: 8]);
        host.stop();
        chk({23'h0, host.ack_all}, 24'h1);
    endtask : wr
    task automatic rd(input logic [7:0] idx, input int n, output logic [15:0] d);
        logic [7:0] b;
        d = 16'h0000;
        host.start();
        host.put(8'hD2);
        host.put(idx);
        host.start();
        host.put(8'hD3);
        host.get(1'b0, b);
        chk({16'h0, b}, {16'h0, BYTE_COUNT_RST});
        for (int i = 0; i < n; i++) begin
            host.get(i == n - 1, b);
            d = {d[7:0], b};
        end
        host.stop();
    endtask : rd
    task automatic halt_check(input logic [7:0] exp);
        halt_n = 1'b0;
        host.edges(6);
        chk({16'h0, clk_ctrl.en}, {16'h0, exp});
        halt_n = 1'b1;
        host.edges(6);
        chk({16'h0, clk_ctrl.en}, {16'h0, sh_oe});
    endtask : halt_check
    initial begin
        #3000000;
        err_count++;
        stop_test();
    end
    initial begin
        do_reset(2'h1);
        chk({4'h0, clk_ctrl}, {4'h0, 8'hFF, 3'h6, 9'h064});
        halt_check(8'hFF);
        // each row: write one byte, read it back, compare the driven controls
        foreach (rows[i]) begin
            wr(rows[i][23:16], {rows[i][15:8], 8'h00}, 8'h01);
            rd(rows[i][23:16], 1, got);
            chk({8'h0, got}, {16'h0, rows[i][7:0]});
            if (rows[i][23:16] == ADDR_OUT_EN) sh_oe = rows[i][7:0];
            if (rows[i][23:16] == ADDR_OUT_CTL) sh_ctl = rows[i][7:0];
            if (rows[i][23:16] == ADDR_DIV_HI) sh_div[8] = rows[i][0];
            if (rows[i][23:16] == ADDR_DIV_LO) sh_div[7:0] = rows[i][7:0];
            chk({4'h0, clk_ctrl}, {4'h0, sh_oe, sh_ctl[5:3], sh_div});
        end
        // two bytes in one block write reach consecutive registers
        wr(8'h04, 16'h01AA, 8'h02);
        chk({15'h0, clk_ctrl.proc_pll_fb_div}, 24'h0001AA);
        rd(8'h04, 2, got);
        chk({8'h0, got}, 24'h00CDAA);
        // pairs 0 and 2 stoppable, pair 1 free-running
        wr(8'h02, 16'hFF35, 8'h02);
        sh_oe = 8'hFF;
        halt_check(8'h5F);
        // clock enable low freezes the halt path until it comes back
        ce = 1'b0;
        halt_n = 1'b0;
        host.edges(6);
        chk({16'h0, clk_ctrl.en}, 24'h0000FF);
        ce = 1'b1;
        host.edges(6);
        chk({16'h0, clk_ctrl.en}, 24'h00005F);
        halt_n = 1'b1;
        host.edges(6);
        chk({16'h0, clk_ctrl.en}, 24'h0000FF);
        // a foreign address is left unanswered
        host.ack_all = 1'b1;
        host.start();
        host.put(8'hA4);
        host.stop();
        chk({23'h0, host.ack_all}, 24'h0);
        // second reset with the 166 MHz strap brings every default back
        do_reset(FS_CODE_166_RST);
        rd(8'h02, 2, got);
        chk({8'h0, got}, 24'h00FF30);
        rd(8'h04, 2, got);
        chk({8'h0, got}, 24'h00CC7D);
        rd(8'h06, 1, got);
        chk({8'h0, got}, 24'h0000C1);
        stop_test();
    end
endmodule : test_clock_output_control_regs
`default_nettype wire
